// ### verilog/pgt_params.svh
// constants for the paired general timer
`ifndef PGT_PARAMS_SVH
`define PGT_PARAMS_SVH
// register indices, byte address is four times the index
`define PGT_IX_LCNT 10'h114
`define PGT_IX_HOLD 10'h116
`define PGT_IX_UCNT 10'h118
`define PGT_IX_LPER 10'h11a
`define PGT_IX_UPER 10'h11c
`define PGT_IX_LCON 10'h11e
`define PGT_IX_UCON 10'h120
`define PGT_IX_FLAG 10'h122
`define PGT_IX_IREN 10'h124
// control field positions
`define PGT_B_RUN 15
`define PGT_B_SIDL 13
`define PGT_B_GATE 6
`define PGT_B_PS_HI 5
`define PGT_B_PS_LO 4
`define PGT_B_PAIR 3
`define PGT_B_CSRC 1
// implemented control bits per timer
`define PGT_LCON_MASK 16'ha07a
`define PGT_UCON_MASK 16'ha072
// reset values
`define PGT_PER_RST 16'hffff
`define PGT_CON_RST 16'h0000
// prescaler terminal counts for 1, 8, 64, 256
`define PGT_PS_LIM1 8'h00
`define PGT_PS_LIM8 8'h07
`define PGT_PS_LIM64 8'h3f
`define PGT_PS_LIM256 8'hff
`define PGT_CNT_TOP 16'hffff
// axi responses
`define PGT_RESP_OKAY 2'h0
`define PGT_RESP_SLVERR 2'h2
`endif

// ### verilog/pgt_pkg.sv
// types shared by the paired general timer
package pgt_pkg;
  typedef logic [15:0] pgt_word_t;
  // prescale select encodings
  typedef enum logic [1:0] {
    PGT_PS_DIV1 = 2'b00,
    PGT_PS_DIV8 = 2'b01,
    PGT_PS_DIV64 = 2'b10,
    PGT_PS_DIV256 = 2'b11
  } pgt_presc_t;
endpackage

// ### verilog/pgt_timer.sv
// paired 16-bit timers with 32-bit mode behind an axi4-lite slave
//
// Functional notes
// [RULE1] two independent 16-bit timers, own registers
// [RULE2] mode set by each control register
// [RULE3] lower is low word, upper high word
// [RULE4] pair mode ignores upper control register
// [RULE5] pair mode uses lower clock and gate
// [RULE6] pair event sets upper flag, upper enable
// [RULE7] no converter trigger output
// [RULE8] no time base for capture/compare
// [RULE9] holding register used only in pair mode
// [RULE10] unimplemented bits read zero
// [RULE11] prescaler 1, 8, 64, 256 by field
// [RULE12] prescaler cleared: count write, run off, reset
// [RULE13] control write keeps count unchanged
// [RULE14] pair flag on 32-bit match or gate fall
// [RULE15] control bit positions fixed
// [RULE16] match restarts at zero next tick
`timescale 1ns/1ns
`include "pgt_params.svh"
module pgt_timer import pgt_pkg::*; (
  input wire logic i_sys_clk, // 20 MHz clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic [11:0] i_awaddr, // write address
  input wire logic i_awvalid, // write address valid
  output logic o_awready, // write address ready
  input wire logic [31:0] i_wdata, // write data
  input wire logic [3:0] i_wstrb, // write strobes
  input wire logic i_wvalid, // write data valid
  output logic o_wready, // write data ready
  output logic [1:0] o_bresp, // write response
  output logic o_bvalid, // write response valid
  input wire logic i_bready, // write response ready
  input wire logic [11:0] i_araddr, // read address
  input wire logic i_arvalid, // read address valid
  output logic o_arready, // read address ready
  output logic [31:0] o_rdata, // read data
  output logic [1:0] o_rresp, // read response
  output logic o_rvalid, // read data valid
  input wire logic i_rready, // read data ready
  input wire logic [1:0] i_ext_clk, // external clock, [0] lower
  input wire logic [1:0] i_ext_gate, // gate input, [0] lower
  input wire logic i_cpu_idle, // cpu idle state
  output logic [1:0] o_timer_irq // flag and enable, [1] upper
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  pgt_word_t cnt_q [2]; // count registers
  pgt_word_t per_q [2]; // period registers
  pgt_word_t con_q [2]; // control registers
  pgt_word_t hold_q; // upper word holding
  logic [7:0] pre_q [2]; // prescaler counters
  logic [1:0] ext_prev_q; // external clock last level
  logic [1:0] gate_prev_q; // gate last level
  logic [1:0] flag_q; // event flags
  logic [1:0] en_q; // event enables
  logic [1:0] irq_q; // interrupt outputs
  // bus side
  logic aw_have_q, w_have_q, awready_q, wready_q, bvalid_q;
  logic [11:0] aw_addr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic arready_q, rvalid_q;
  logic [31:0] rdata_q;

  function automatic pgt_word_t merge16(input pgt_word_t old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  wire [9:0] aw_ix = aw_addr_q[11:2];
  wire wr_fire = aw_have_q & w_have_q & ~bvalid_q;
  wire hit_lcnt = wr_fire & (aw_ix == `PGT_IX_LCNT);
  wire hit_hold = wr_fire & (aw_ix == `PGT_IX_HOLD);
  wire hit_ucnt = wr_fire & (aw_ix == `PGT_IX_UCNT);
  wire hit_lper = wr_fire & (aw_ix == `PGT_IX_LPER);
  wire hit_uper = wr_fire & (aw_ix == `PGT_IX_UPER);
  wire hit_lcon = wr_fire & (aw_ix == `PGT_IX_LCON);
  wire hit_ucon = wr_fire & (aw_ix == `PGT_IX_UCON);
  wire hit_flag = wr_fire & (aw_ix == `PGT_IX_FLAG);
  wire hit_iren = wr_fire & (aw_ix == `PGT_IX_IREN);
  wire wr_map = hit_lcnt | hit_hold | hit_ucnt | hit_lper | hit_uper |
                hit_lcon | hit_ucon | hit_flag | hit_iren;
  // pair mode comes from the lower control only
  wire pair = con_q[0][`PGT_B_PAIR]; // [RULE4]
  wire [1:0] cnt_load = {hit_ucnt | (hit_lcnt & pair), hit_lcnt};
  wire [1:0] per_load = {hit_uper, hit_lper};
  wire [1:0] con_load = {hit_ucon, hit_lcon};
  wire [15:0] con_mask [2];
  assign con_mask[0] = `PGT_LCON_MASK;
  assign con_mask[1] = `PGT_UCON_MASK;
  // lower count write in pair mode moves the holding word up
  wire [15:0] cnt_wval [2];
  assign cnt_wval[0] = merge16(cnt_q[0], wdata_q, wstrb_q);
  assign cnt_wval[1] = (hit_lcnt & pair) ? hold_q : merge16(cnt_q[1], wdata_q, wstrb_q); // [RULE9]

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  wire [9:0] ar_ix = i_araddr[11:2];
  wire ar_fire = i_arvalid & arready_q;
  wire rd_lcnt = ar_ix == `PGT_IX_LCNT;
  wire rd_hold = ar_ix == `PGT_IX_HOLD;
  wire rd_ucnt = ar_ix == `PGT_IX_UCNT;
  wire rd_lper = ar_ix == `PGT_IX_LPER;
  wire rd_uper = ar_ix == `PGT_IX_UPER;
  wire rd_lcon = ar_ix == `PGT_IX_LCON;
  wire rd_ucon = ar_ix == `PGT_IX_UCON;
  wire rd_flag = ar_ix == `PGT_IX_FLAG;
  wire rd_iren = ar_ix == `PGT_IX_IREN;
  wire rd_map = rd_lcnt | rd_hold | rd_ucnt | rd_lper | rd_uper | rd_lcon | rd_ucon | rd_flag | rd_iren;
  // upper 16 bits and unused control bits always read zero
  wire [15:0] rd_val = rd_lcnt ? cnt_q[0] : rd_hold ? hold_q : rd_ucnt ? cnt_q[1] :
                       rd_lper ? per_q[0] : rd_uper ? per_q[1] : rd_lcon ? con_q[0] :
                       rd_ucon ? con_q[1] : rd_flag ? {14'h0000, flag_q} :
                       rd_iren ? {14'h0000, en_q} : 16'h0000; // [RULE10]

  // ----------------------------------------
  // counting terms
  // ----------------------------------------
  logic [1:0] run, src_pulse, tick_raw, gate_fall, ton_fall;
  logic [7:0] pre_lim [2];
  wire match32 = ({cnt_q[1], cnt_q[0]} == {per_q[1], per_q[0]}); // [RULE3]
  wire [1:0] match16 = {cnt_q[1] == per_q[1], cnt_q[0] == per_q[0]};
  // upper path is silenced in pair mode, the lower path drives both words
  wire tick0 = tick_raw[0]; // [RULE5]
  wire tick1 = tick_raw[1] & ~pair; // [RULE4]
  wire [1:0] step = {pair ? (tick0 & (match32 | (cnt_q[0] == `PGT_CNT_TOP))) : tick1, tick0};
  wire [1:0] wrap = pair ? {match32, match32} : match16; // [RULE16]
  // match events stay internal: no converter trigger [RULE7] and no shared time base [RULE8]
  wire [1:0] flag_set;
  assign flag_set[0] = ~pair & ((tick0 & match16[0]) | gate_fall[0]);
  assign flag_set[1] = pair ? ((tick0 & match32) | gate_fall[0]) :
                       ((tick1 & match16[1]) | gate_fall[1]); // [RULE6] [RULE14]
  wire [15:0] flag_wr = hit_flag ? merge16({14'h0000, flag_q}, wdata_q, wstrb_q) : {14'h0000, flag_q};

  // ----------------------------------------
  // per timer logic
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_tmr
      wire [15:0] con_new = merge16(con_q[gi], wdata_q, wstrb_q) & con_mask[gi];
      // each timer runs from its own control bits
      assign run[gi] = con_q[gi][`PGT_B_RUN] & ~(con_q[gi][`PGT_B_SIDL] & i_cpu_idle); // [RULE1] [RULE2] [RULE15]
      assign src_pulse[gi] = con_q[gi][`PGT_B_CSRC] ? (i_ext_clk[gi] & ~ext_prev_q[gi]) :
                             (con_q[gi][`PGT_B_GATE] ? i_ext_gate[gi] : 1'b1);
      assign gate_fall[gi] = run[gi] & con_q[gi][`PGT_B_GATE] & ~con_q[gi][`PGT_B_CSRC] &
                             gate_prev_q[gi] & ~i_ext_gate[gi];
      assign pre_lim[gi] = (con_q[gi][`PGT_B_PS_HI:`PGT_B_PS_LO] == PGT_PS_DIV1) ? `PGT_PS_LIM1 :
                           (con_q[gi][`PGT_B_PS_HI:`PGT_B_PS_LO] == PGT_PS_DIV8) ? `PGT_PS_LIM8 :
                           (con_q[gi][`PGT_B_PS_HI:`PGT_B_PS_LO] == PGT_PS_DIV64) ? `PGT_PS_LIM64 :
                           `PGT_PS_LIM256; // [RULE11]
      assign tick_raw[gi] = run[gi] & src_pulse[gi] & (pre_q[gi] == pre_lim[gi]);
      assign ton_fall[gi] = con_load[gi] & con_q[gi][`PGT_B_RUN] & ~con_new[`PGT_B_RUN];

      // prescaler: count source pulses, restart on count write or run off
      always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          pre_q[gi] <= 8'h00; // [RULE12]
        end else if (cnt_load[gi] | ton_fall[gi] | (pair & cnt_load[1])) begin
          pre_q[gi] <= 8'h00; // [RULE12]
        end else if (run[gi] & src_pulse[gi]) begin
          pre_q[gi] <= tick_raw[gi] ? 8'h00 : pre_q[gi] + 8'h01;
        end
      end

      // count: software write beats the hardware step
      always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          cnt_q[gi] <= 16'h0000;
        end else if (cnt_load[gi]) begin
          cnt_q[gi] <= cnt_wval[gi];
        end else if (step[gi]) begin
          cnt_q[gi] <= wrap[gi] ? 16'h0000 : cnt_q[gi] + 16'h0001; // [RULE16]
        end
      end

      // period and control, control writes never touch the count
      always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          per_q[gi] <= `PGT_PER_RST;
          con_q[gi] <= `PGT_CON_RST;
        end else begin
          if (per_load[gi]) begin
            per_q[gi] <= merge16(per_q[gi], wdata_q, wstrb_q);
          end
          if (con_load[gi]) begin
            con_q[gi] <= con_new; // [RULE13]
          end
        end
      end

      // edge history, flags (set wins over clear) and interrupt line
      always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          ext_prev_q[gi] <= 1'b0;
          gate_prev_q[gi] <= 1'b0;
          flag_q[gi] <= 1'b0;
          en_q[gi] <= 1'b0;
          irq_q[gi] <= 1'b0;
        end else begin
          ext_prev_q[gi] <= i_ext_clk[gi];
          gate_prev_q[gi] <= i_ext_gate[gi];
          flag_q[gi] <= flag_set[gi] | flag_wr[gi];
          if (hit_iren & wstrb_q[0]) begin
            en_q[gi] <= wdata_q[gi];
          end
          irq_q[gi] <= flag_q[gi] & en_q[gi]; // [RULE6]
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // holding register
  // ----------------------------------------
  // a lower count read in pair mode snapshots the upper word,
  // so a two-read sequence sees one coherent 32-bit value
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold_q <= 16'h0000;
    end else if (ar_fire & rd_lcnt & pair) begin
      hold_q <= cnt_q[1]; // [RULE9]
    end else if (hit_hold) begin
      hold_q <= merge16(hold_q, wdata_q, wstrb_q);
    end
  end

  // ----------------------------------------
  // axi write channel
  // ----------------------------------------
  // address and data are caught in either order, one write at a time
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `PGT_RESP_OKAY;
      aw_addr_q <= 12'h000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (i_awvalid & awready_q) begin
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
        aw_addr_q <= i_awaddr;
      end
      if (i_wvalid & wready_q) begin
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_map ? `PGT_RESP_OKAY : `PGT_RESP_SLVERR;
      end
      if (bvalid_q & i_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // axi read channel
  // ----------------------------------------
  // data is captured at the address handshake, answer one edge later
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `PGT_RESP_OKAY;
    end else if (ar_fire) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= {16'h0000, rd_val}; // [RULE10]
      rresp_q <= rd_map ? `PGT_RESP_OKAY : `PGT_RESP_SLVERR;
    end else if (rvalid_q & i_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign o_awready = awready_q;
  assign o_wready = wready_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign o_arready = arready_q;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;
  assign o_timer_irq = irq_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_bvalid_held: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_bvalid & ~i_bready |=> o_bvalid)
    else $error("write response dropped early");
  a_rvalid_held: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_rvalid & ~i_rready |=> o_rvalid & $stable(o_rdata))
    else $error("read data dropped early");
  a_rdata_upper_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE10]
    o_rvalid |-> o_rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_pre_clear_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE12]
    cnt_load[0] |=> pre_q[0] == 8'h00)
    else $error("prescaler not cleared by count write");
  a_ctrl_keeps_count: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE13]
    hit_lcon & ~step[0] & ~cnt_load[0] |=> $stable(cnt_q[0]))
    else $error("control write changed count");
  a_wrap_to_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE16]
    step[0] & wrap[0] & ~cnt_load[0] |=> cnt_q[0] == 16'h0000)
    else $error("count did not restart at zero");
  a_pair_upper_flag: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE6]
    pair & tick0 & match32 |=> flag_q[1] ##1 irq_q[1] == $past(en_q[1]))
    else $error("pair match missed upper flag");
  a_pair_lower_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE6]
    pair & ~flag_q[0] & ~hit_flag |=> ~flag_q[0])
    else $error("lower flag set in pair mode");
  a_hold_snapshot: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE9]
    ar_fire & rd_lcnt & pair |=> hold_q == $past(cnt_q[1]))
    else $error("holding word not captured");
  a_prescale_div8: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE11]
    tick_raw[0] & (con_q[0][`PGT_B_PS_HI:`PGT_B_PS_LO] == PGT_PS_DIV8) |-> pre_q[0] == 8'h07)
    else $error("div8 tick at wrong prescale count");
endmodule

// ### verif/tb.sv
// self-checking bench for the paired general timer
`timescale 1ns/1ns
`include "pgt_params.svh"
module tb import pgt_pkg::*; ;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic i_sys_clk, i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_cpu_idle;
  logic [11:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata;
  logic [3:0] i_wstrb;
  logic [1:0] i_ext_clk, i_ext_gate;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp, o_timer_irq;
  logic [31:0] o_rdata;
  int n_fail, compares, k;
  int dv [4] = '{1, 8, 64, 256}; // divide ratio per prescale code
  logic [9:0] ix_tab [7] = '{`PGT_IX_LCNT, `PGT_IX_HOLD, `PGT_IX_UCNT, `PGT_IX_LPER, `PGT_IX_UPER,
                             `PGT_IX_LCON, `PGT_IX_UCON};
  logic [15:0] rv_tab [7] = '{16'h0000, 16'h0000, 16'h0000, `PGT_PER_RST, `PGT_PER_RST,
                              `PGT_CON_RST, `PGT_CON_RST};

  pgt_timer i_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_awaddr(i_awaddr),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
    .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
    .i_ext_clk(i_ext_clk), .i_ext_gate(i_ext_gate), .i_cpu_idle(i_cpu_idle),
    .o_timer_irq(o_timer_irq));

  // ----------------------------------------
  // clock: 50 ns period
  // ----------------------------------------
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  // ----------------------------------------
  // compare, verdict and bus tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // axi write: address and data offered together, bready held until bvalid
  task automatic wr(input logic [9:0] ix, input logic [15:0] d, input logic [1:0] er);
    int n;
    @(posedge i_sys_clk);
    i_awaddr <= {ix, 2'b00};
    i_wdata <= {16'h0000, d};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_sys_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      if (o_bvalid) begin
        chk("bresp", {30'h0, er}, {30'h0, o_bresp});
        break;
      end
    end
    i_bready <= 1'b0;
    if (n == 50) begin
      n_fail++;
      conclude();
    end
  endtask

  // axi read: data and response taken at the rvalid edge
  task automatic rd(input logic [9:0] ix, input logic [15:0] exp, input logic [1:0] er);
    int n;
    @(posedge i_sys_clk);
    i_araddr <= {ix, 2'b00};
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_sys_clk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (o_rvalid) begin
        chk("rdata", {16'h0000, exp}, o_rdata);
        chk("rresp", {30'h0, er}, {30'h0, o_rresp});
        break;
      end
    end
    i_rready <= 1'b0;
    if (n == 50) begin
      n_fail++;
      conclude();
    end
  endtask

  // external count pulses, one cycle high and one low each
  task automatic pulse(input logic [1:0] m, input int n);
    repeat (n) begin
      @(posedge i_sys_clk);
      i_ext_clk <= m;
      @(posedge i_sys_clk);
      i_ext_clk <= 2'b00;
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_cpu_idle} = 6'h00;
    i_awaddr = 12'h000;
    i_araddr = 12'h000;
    i_wdata = 32'h0000_0000;
    i_wstrb = 4'hf; // all lanes, upper two are ignored
    i_ext_clk = 2'b00;
    i_ext_gate = 2'b00;
    n_fail = 0;
    compares = 0;
    i_rst_n = 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    // reset values of the register table
    for (k = 0; k < 7; k++) rd(ix_tab[k], rv_tab[k], `PGT_RESP_OKAY);
    // control bit positions; unimplemented bits read zero
    wr(`PGT_IX_LCON, 16'h7fff, `PGT_RESP_OKAY);
    rd(`PGT_IX_LCON, 16'h7fff & `PGT_LCON_MASK, `PGT_RESP_OKAY);
    wr(`PGT_IX_UCON, 16'h7fff, `PGT_RESP_OKAY);
    rd(`PGT_IX_UCON, 16'h7fff & `PGT_UCON_MASK, `PGT_RESP_OKAY);
    wr(`PGT_IX_LCON, 16'h0000, `PGT_RESP_OKAY);
    wr(`PGT_IX_UCON, 16'h0000, `PGT_RESP_OKAY);
    // unmapped place is refused, read gives zero
    wr(10'h130, 16'h1234, `PGT_RESP_SLVERR);
    rd(10'h130, 16'h0000, `PGT_RESP_SLVERR);
    // prescale codes: partial prescale discarded by a count write, stop keeps count
    for (k = 0; k < 4; k++) begin
      wr(`PGT_IX_LCNT, 16'h0000, `PGT_RESP_OKAY);
      wr(`PGT_IX_LCON, 16'h8002 | (16'(k) << 4), `PGT_RESP_OKAY);
      pulse(2'b01, dv[k] - 1);
      wr(`PGT_IX_LCNT, 16'h0000, `PGT_RESP_OKAY);
      pulse(2'b01, 3 * dv[k] - 1);
      wr(`PGT_IX_LCON, 16'h0002 | (16'(k) << 4), `PGT_RESP_OKAY);
      rd(`PGT_IX_LCNT, 16'h0002, `PGT_RESP_OKAY);
    end
    // independent 16-bit timers; lower wraps at period plus one
    wr(`PGT_IX_LPER, 16'h0002, `PGT_RESP_OKAY);
    wr(`PGT_IX_LCNT, 16'h0000, `PGT_RESP_OKAY);
    wr(`PGT_IX_UCNT, 16'h0000, `PGT_RESP_OKAY);
    wr(`PGT_IX_IREN, 16'h0001, `PGT_RESP_OKAY);
    wr(`PGT_IX_LCON, 16'h8002, `PGT_RESP_OKAY);
    wr(`PGT_IX_UCON, 16'h8002, `PGT_RESP_OKAY);
    pulse(2'b11, 2);
    rd(`PGT_IX_LCNT, 16'h0002, `PGT_RESP_OKAY);
    rd(`PGT_IX_FLAG, 16'h0000, `PGT_RESP_OKAY);
    pulse(2'b11, 1);
    rd(`PGT_IX_LCNT, 16'h0000, `PGT_RESP_OKAY);
    rd(`PGT_IX_UCNT, 16'h0003, `PGT_RESP_OKAY);
    rd(`PGT_IX_FLAG, 16'h0001, `PGT_RESP_OKAY);
    chk("irq", 32'h1, {30'h0, o_timer_irq});
    wr(`PGT_IX_LCON, 16'h000a, `PGT_RESP_OKAY);
    wr(`PGT_IX_FLAG, 16'h0000, `PGT_RESP_OKAY);
    // 32-bit pair: upper control left running to show it is ignored
    wr(`PGT_IX_LPER, 16'h0001, `PGT_RESP_OKAY);
    wr(`PGT_IX_UPER, 16'h0002, `PGT_RESP_OKAY);
    wr(`PGT_IX_HOLD, 16'h0001, `PGT_RESP_OKAY);
    wr(`PGT_IX_LCNT, 16'hfffe, `PGT_RESP_OKAY);
    wr(`PGT_IX_IREN, 16'h0002, `PGT_RESP_OKAY);
    wr(`PGT_IX_LCON, 16'h800a, `PGT_RESP_OKAY);
    pulse(2'b11, 3);
    rd(`PGT_IX_LCNT, 16'h0001, `PGT_RESP_OKAY);
    rd(`PGT_IX_HOLD, 16'h0002, `PGT_RESP_OKAY);
    rd(`PGT_IX_FLAG, 16'h0000, `PGT_RESP_OKAY);
    pulse(2'b11, 1);
    rd(`PGT_IX_FLAG, 16'h0002, `PGT_RESP_OKAY);
    rd(`PGT_IX_LCNT, 16'h0000, `PGT_RESP_OKAY);
    rd(`PGT_IX_HOLD, 16'h0000, `PGT_RESP_OKAY);
    chk("irq", 32'h2, {30'h0, o_timer_irq});
    wr(`PGT_IX_IREN, 16'h0000, `PGT_RESP_OKAY);
    repeat (2) @(posedge i_sys_clk);
    chk("irq", 32'h0, {30'h0, o_timer_irq});
    wr(`PGT_IX_FLAG, 16'h0000, `PGT_RESP_OKAY);
    rd(`PGT_IX_FLAG, 16'h0000, `PGT_RESP_OKAY);
    // gate falling edge in pair mode raises the upper flag
    wr(`PGT_IX_LCON, 16'h0008, `PGT_RESP_OKAY);
    wr(`PGT_IX_LPER, 16'hffff, `PGT_RESP_OKAY);
    wr(`PGT_IX_UPER, 16'hffff, `PGT_RESP_OKAY);
    wr(`PGT_IX_LCON, 16'h8048, `PGT_RESP_OKAY);
    @(posedge i_sys_clk);
    i_ext_gate <= 2'b01;
    repeat (5) @(posedge i_sys_clk);
    i_ext_gate <= 2'b00;
    repeat (4) @(posedge i_sys_clk);
    rd(`PGT_IX_FLAG, 16'h0002, `PGT_RESP_OKAY);
    wr(`PGT_IX_LCON, 16'h0000, `PGT_RESP_OKAY);
    wr(`PGT_IX_UCON, 16'h0000, `PGT_RESP_OKAY);
    // stop in idle: held while idle, counts again once the bit is dropped
    wr(`PGT_IX_LCNT, 16'h0000, `PGT_RESP_OKAY);
    i_cpu_idle <= 1'b1;
    wr(`PGT_IX_LCON, 16'ha000, `PGT_RESP_OKAY);
    rd(`PGT_IX_LCNT, 16'h0000, `PGT_RESP_OKAY);
    wr(`PGT_IX_LCON, 16'h8000, `PGT_RESP_OKAY);
    wr(`PGT_IX_LCON, 16'h0000, `PGT_RESP_OKAY);
    rd(`PGT_IX_LCNT, 16'h0004, `PGT_RESP_OKAY);
    i_cpu_idle <= 1'b0;
    conclude();
  end
endmodule
